// ---- irq_route_pkg.sv ----
// Purpose: Shared constants for the PCI interrupt rerouter
// Assumes: Byte-wide ISA I/O write port, one system clock
// Notes: Routing codes are 4-bit nibbles, one per PCI interrupt line
package irq_route_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [15:0] ROUTE_CTRL_LO_ADDR = 16'h0CA4;
  localparam logic [15:0] ROUTE_CTRL_HI_ADDR = 16'h0CA5;
  localparam logic [7:0] ROUTE_CTRL_RESET = 8'h00;
  localparam int LINE_COUNT = 4;
  localparam int IRQ_COUNT = 16;
  // ----------------------------------------
  // Routing codes
  // ----------------------------------------
  typedef enum logic [3:0] {
    ROUTE_APIC = 4'h0,
    ROUTE_IRQ3 = 4'h3,
    ROUTE_IRQ5 = 4'h5,
    ROUTE_IRQ7 = 4'h7,
    ROUTE_IRQ9 = 4'h9,
    ROUTE_IRQ10 = 4'hA,
    ROUTE_IRQ11 = 4'hB,
    ROUTE_IRQ15 = 4'hF
  } route_code_t;
endpackage

// ---- irq_route_lane.sv ----
// Purpose: Decode one routing nibble and steer one PCI interrupt line
// Assumes: intActive is an active-high, already synchronised request
// Notes: Combinational; the top registers the results
`timescale 1ns/100ps
module irq_route_lane (
  // Control
  input wire logic [3:0] code,
  input wire logic intActive,
  // Results
  output logic apicActive,
  output logic [15:0] isaIrq
);
  import irq_route_pkg::*;

  logic legal;

  always_comb begin
    legal = 1'b1;
    isaIrq = 16'h0000;
    unique case (code)
      ROUTE_IRQ3, ROUTE_IRQ5, ROUTE_IRQ7, ROUTE_IRQ9,
      ROUTE_IRQ10, ROUTE_IRQ11, ROUTE_IRQ15: begin
        isaIrq[code] = intActive;
      end
      default: begin
        // Code 0 and reserved codes both fall back to pass-through
        legal = 1'b0;
      end
    endcase
    apicActive = intActive & ~legal;
  end
endmodule

// ---- pci_irq_rerouter.sv ----
// Function
// - Two write-only control bytes live at I/O addresses CA4h and CA5h.
// - Each nibble steers one PCI interrupt to the APIC or an ISA IRQ.
// - Even byte holds lines A (low) and B; odd byte lines C and D.
// - Code zero passes the line to the APIC and is the reset value.
// - Codes 3,5,7,9,A,B,F redirect the line to the same-numbered IRQ.
//
// Purpose: PCI interrupt to ISA IRQ rerouter behind a chip-selected I/O port
// Assumes: ioWrite, chip select, address and data from same-clock bus logic
// Notes: PCI interrupt pins are asynchronous and pass two flip-flops
`timescale 1ns/100ps
module pci_irq_rerouter (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // ISA I/O write port
  input wire logic chipSel,
  input wire logic ioWrite,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioData,
  // PCI interrupt inputs, active low
  input wire logic pci_int_line_a_n,
  input wire logic pci_int_line_b_n,
  input wire logic pci_int_line_c_n,
  input wire logic pci_int_line_d_n,
  // Interrupt outputs, active high
  output logic [3:0] apicInt,
  output logic [15:0] isaIrq
);
  import irq_route_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rstSync1_r, rstnSync_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstSync1_r <= 1'b0;
      rstnSync_r <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstnSync_r <= rstSync1_r;
    end
  end

  // ----------------------------------------
  // Control bytes
  // ----------------------------------------
  logic [7:0] ctrlLo_r, ctrlLo_nxt, ctrlHi_r, ctrlHi_nxt;
  always_comb begin
    ctrlLo_nxt = ctrlLo_r;
    ctrlHi_nxt = ctrlHi_r;
    // Full address is matched as well as chip select so aliases stay quiet
    if (chipSel && ioWrite && ioAddr == ROUTE_CTRL_LO_ADDR) begin
      ctrlLo_nxt = ioData;
    end
    if (chipSel && ioWrite && ioAddr == ROUTE_CTRL_HI_ADDR) begin
      ctrlHi_nxt = ioData;
    end
  end
  always_ff @(posedge clock or negedge rstnSync_r) begin
    if (!rstnSync_r) begin
      ctrlLo_r <= ROUTE_CTRL_RESET;
      ctrlHi_r <= ROUTE_CTRL_RESET;
    end else begin
      ctrlLo_r <= ctrlLo_nxt;
      ctrlHi_r <= ctrlHi_nxt;
    end
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [3:0] intMeta_r, intSync_r;
  always_ff @(posedge clock or negedge rstnSync_r) begin
    if (!rstnSync_r) begin
      intMeta_r <= 4'h0;
      intSync_r <= 4'h0;
    end else begin
      intMeta_r <= ~{pci_int_line_d_n, pci_int_line_c_n, pci_int_line_b_n, pci_int_line_a_n};
      intSync_r <= intMeta_r;
    end
  end

  // ----------------------------------------
  // Steering
  // ----------------------------------------
  logic [3:0] codes [LINE_COUNT];
  logic [3:0] apicNxt;
  logic [15:0] laneIrq [LINE_COUNT];
  logic [15:0] isaNxt;
  assign codes[0] = ctrlLo_r[3:0];
  assign codes[1] = ctrlLo_r[7:4];
  assign codes[2] = ctrlHi_r[3:0];
  assign codes[3] = ctrlHi_r[7:4];

  genvar g;
  generate
    for (g = 0; g < LINE_COUNT; g++) begin : gLane
      irq_route_lane uLane (
        .code(codes[g]),
        .intActive(intSync_r[g]),
        .apicActive(apicNxt[g]),
        .isaIrq(laneIrq[g])
      );
    end
  endgenerate

  // Lines sharing an IRQ are ORed, as on a shared level-triggered input
  always_comb begin
    isaNxt = 16'h0000;
    for (int i = 0; i < LINE_COUNT; i++) begin
      isaNxt = isaNxt | laneIrq[i];
    end
  end

  always_ff @(posedge clock or negedge rstnSync_r) begin
    if (!rstnSync_r) begin
      apicInt <= 4'h0;
      isaIrq <= 16'h0000;
    end else begin
      apicInt <= apicNxt;
      isaIrq <= isaNxt;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  function automatic logic legalRoute(input logic [3:0] c);
    legalRoute = (c == 4'h3) || (c == 4'h5) || (c == 4'h7) || (c == 4'h9) ||
                 (c == 4'hA) || (c == 4'hB) || (c == 4'hF);
  endfunction

  sequence s_loWrite;
    chipSel && ioWrite && ioAddr == ROUTE_CTRL_LO_ADDR;
  endsequence

  property p_lo_write;
    @(posedge clock) disable iff (!rstnSync_r) s_loWrite |=> ctrlLo_r == $past(ioData);
  endproperty
  a_lo_write: assert property (p_lo_write) else $error("Low control byte not stored");

  property p_hi_write;
    @(posedge clock) disable iff (!rstnSync_r)
      chipSel && ioWrite && ioAddr == ROUTE_CTRL_HI_ADDR |=> ctrlHi_r == $past(ioData);
  endproperty
  a_hi_write: assert property (p_hi_write) else $error("High control byte not stored");

  property p_no_stray;
    @(posedge clock) disable iff (!rstnSync_r)
      !(chipSel && ioWrite) |=> $stable(ctrlLo_r) && $stable(ctrlHi_r);
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("Control byte changed without write");

  property p_pass_a;
    @(posedge clock) disable iff (!rstnSync_r)
      !legalRoute(ctrlLo_r[3:0]) && $stable(ctrlLo_r) |=> apicInt[0] == $past(intSync_r[0]);
  endproperty
  a_pass_a: assert property (p_pass_a) else $error("Line A not passed to APIC");

  property p_route_a;
    @(posedge clock) disable iff (!rstnSync_r)
      legalRoute(ctrlLo_r[3:0]) && intSync_r[0] |=> isaIrq[$past(ctrlLo_r[3:0])] && !apicInt[0];
  endproperty
  a_route_a: assert property (p_route_a) else $error("Line A not redirected");

  property p_route_d;
    @(posedge clock) disable iff (!rstnSync_r)
      legalRoute(ctrlHi_r[7:4]) && intSync_r[3] |=> isaIrq[$past(ctrlHi_r[7:4])] && !apicInt[3];
  endproperty
  a_route_d: assert property (p_route_d) else $error("Line D not redirected");

  property p_reserved_quiet;
    @(posedge clock) disable iff (!rstnSync_r)
      1'b1 |=> (isaIrq & 16'h7157) == 16'h0000;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) else $error("Unroutable IRQ driven");

  property p_one_way;
    @(posedge clock) disable iff (!rstnSync_r)
      apicInt[1] |-> !legalRoute($past(ctrlLo_r[7:4]));
  endproperty
  a_one_way: assert property (p_one_way) else $error("Line B sent to APIC and ISA");

  property p_pass_b;
    @(posedge clock) disable iff (!rstnSync_r)
      !legalRoute(ctrlLo_r[7:4]) |=> apicInt[1] == $past(intSync_r[1]);
  endproperty
  a_pass_b: assert property (p_pass_b) else $error("Line B not passed to APIC");

  property p_pass_c;
    @(posedge clock) disable iff (!rstnSync_r)
      !legalRoute(ctrlHi_r[3:0]) |=> apicInt[2] == $past(intSync_r[2]);
  endproperty
  a_pass_c: assert property (p_pass_c) else $error("Line C not passed to APIC");

  property p_pass_d;
    @(posedge clock) disable iff (!rstnSync_r)
      !legalRoute(ctrlHi_r[7:4]) |=> apicInt[3] == $past(intSync_r[3]);
  endproperty
  a_pass_d: assert property (p_pass_d) else $error("Line D not passed to APIC");

  property p_route_b;
    @(posedge clock) disable iff (!rstnSync_r)
      legalRoute(ctrlLo_r[7:4]) && intSync_r[1] |=> isaIrq[$past(ctrlLo_r[7:4])] && !apicInt[1];
  endproperty
  a_route_b: assert property (p_route_b) else $error("Line B not redirected");

  property p_route_c;
    @(posedge clock) disable iff (!rstnSync_r)
      legalRoute(ctrlHi_r[3:0]) && intSync_r[2] |=> isaIrq[$past(ctrlHi_r[3:0])] && !apicInt[2];
  endproperty
  a_route_c: assert property (p_route_c) else $error("Line C not redirected");

  // No pending line means nothing may reach either controller
  property p_idle_quiet;
    @(posedge clock) disable iff (!rstnSync_r)
      intSync_r == 4'h0 |=> apicInt == 4'h0 && isaIrq == 16'h0000;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("Output driven with no request");

  // Other ports under the same chip select must leave routing alone
  sequence s_otherWrite;
    chipSel && ioWrite && ioAddr != ROUTE_CTRL_LO_ADDR && ioAddr != ROUTE_CTRL_HI_ADDR;
  endsequence

  property p_alias_quiet;
    @(posedge clock) disable iff (!rstnSync_r)
      s_otherWrite |=> $stable(ctrlLo_r) && $stable(ctrlHi_r);
  endproperty
  a_alias_quiet: assert property (p_alias_quiet) else $error("Control byte changed by other port");
endmodule

// ---- isa_io_host.sv ----
// Purpose: Host side of the ISA I/O write port of the rerouter
// Assumes: One request cycle from the bench makes one write cycle
// Notes: Address and data lines show a toggling pattern when idle
`timescale 1ns/100ps
module isa_io_host (
  // Clock
  input wire logic clock,
  // Bench request
  input wire logic req,
  input wire logic sel,
  input wire logic [15:0] reqAddr,
  input wire logic [7:0] reqData,
  // ISA I/O write port
  output logic chipSel,
  output logic ioWrite,
  output logic [15:0] ioAddr,
  output logic [7:0] ioData
);
  initial begin
    chipSel = 1'b0;
    ioWrite = 1'b0;
    ioAddr = 16'h0000;
    ioData = 8'h00;
  end
  // Idle bus never holds the last value, so stale data cannot pass for a write
  always @(posedge clock) begin
    chipSel <= req & sel;
    ioWrite <= req;
    ioAddr <= req ? reqAddr : ~ioAddr;
    ioData <= req ? reqData : ~ioData;
  end
endmodule

// ---- tb_pci_irq_rerouter.sv ----
// Purpose: Self-checking bench for the PCI interrupt rerouter
// Assumes: Host model turns a one-cycle request into one I/O write
// Notes: Fixed settle covers the write path and the two-flop pin sync
`timescale 1ns/100ps
module tb_pci_irq_rerouter;
  import irq_route_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic req = 1'b0;
  logic sel = 1'b0;
  logic [15:0] reqAddr = 16'h0000;
  logic [7:0] reqData = 8'h00;
  logic [3:0] intN = 4'hF;
  logic chipSel, ioWrite;
  logic [15:0] ioAddr;
  logic [7:0] ioData;
  logic [3:0] apicInt;
  logic [15:0] isaIrq;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [3:0] good [7] = '{4'h3, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hF};
  logic [3:0] rsvd [8] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hC, 4'hD, 4'hE};
  always #4 clock = ~clock;
  isa_io_host host (.clock(clock), .req(req), .sel(sel), .reqAddr(reqAddr), .reqData(reqData),
    .chipSel(chipSel), .ioWrite(ioWrite), .ioAddr(ioAddr), .ioData(ioData));
  pci_irq_rerouter dut (.clock(clock), .rstn(rstn), .chipSel(chipSel), .ioWrite(ioWrite), .ioAddr(ioAddr),
    .ioData(ioData), .pci_int_line_a_n(intN[0]), .pci_int_line_b_n(intN[1]), .pci_int_line_c_n(intN[2]),
    .pci_int_line_d_n(intN[3]), .apicInt(apicInt), .isaIrq(isaIrq));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      finish_test();
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic s, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= 1'b1;
    sel <= s;
    reqAddr <= a;
    reqData <= d;
    @(posedge clock);
    req <= 1'b0;
  endtask
  task automatic route(input logic [15:0] c);
    wr(1'b1, ROUTE_CTRL_LO_ADDR, c[7:0]);
    wr(1'b1, ROUTE_CTRL_HI_ADDR, c[15:8]);
  endtask
  // Sample one step after the edge so registered outputs have landed
  task automatic pins(input logic [3:0] v);
    @(posedge clock);
    intN <= v;
    repeat (6) @(posedge clock);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    pins(4'hF);
    cmp({12'h000, apicInt}, 16'h0000);
    cmp(isaIrq, 16'h0000);
    pins(4'h0);
    cmp({12'h000, apicInt}, 16'h000F);
    cmp(isaIrq, 16'h0000);
    $display("test reset done");
  endtask
  task automatic test_codes();
    for (int i = 0; i < 7; i++) begin
      for (int l = 0; l < 4; l++) begin
        route({12'h000, good[i]} << (4 * l));
        pins(4'h0);
        cmp({12'h000, apicInt}, 16'(4'hF & ~(4'h1 << l)));
        cmp(isaIrq, 16'h0001 << good[i]);
      end
    end
    $display("test codes done");
  endtask
  task automatic test_reserved();
    for (int i = 0; i < 8; i++) begin
      route({4{rsvd[i]}});
      pins(4'h0);
      cmp({12'h000, apicInt}, 16'h000F);
      cmp(isaIrq, 16'h0000);
    end
    $display("test reserved done");
  endtask
  task automatic test_refused();
    route(16'h3333);
    wr(1'b0, ROUTE_CTRL_LO_ADDR, 8'h00);
    wr(1'b1, 16'h0CA6, 8'h00);
    pins(4'hE);
    cmp({12'h000, apicInt}, 16'h0000);
    cmp(isaIrq, 16'h0008);
    pins(4'hF);
    cmp({12'h000, apicInt}, 16'h0000);
    cmp(isaIrq, 16'h0000);
    $display("test refused done");
  endtask
  // All four lines share one IRQ, then a reset in mid-run restores pass-through
  task automatic test_shared_reset();
    route(16'h3333);
    pins(4'h0);
    cmp({12'h000, apicInt}, 16'h0000);
    cmp(isaIrq, 16'h0008);
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    pins(4'h0);
    cmp({12'h000, apicInt}, 16'h000F);
    cmp(isaIrq, 16'h0000);
    $display("test shared reset done");
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    test_reset();
    test_codes();
    test_reserved();
    test_refused();
    test_shared_reset();
    finish_test();
  end
endmodule
